// *** inc/lsr_consts.svh ***
// Register map, field positions and reset values of the result/config bank
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH

`define LSR_ADDR_STATUS    8'h93
`define LSR_ADDR_RED_HI    8'h97
`define LSR_ADDR_GRN_LO    8'h98
`define LSR_ADDR_GRN_HI    8'h99
`define LSR_ADDR_BLU_LO    8'h9A
`define LSR_ADDR_BLU_HI    8'h9B
`define LSR_ADDR_PROX      8'h9C
`define LSR_ADDR_PKG_ID    8'h9E
`define LSR_ADDR_GAIN_CFG  8'h9F
`define LSR_ADDR_INT_CFG   8'hAB
`define LSR_ADDR_OFF_MAG   8'hC0
`define LSR_ADDR_OFF_SIGN  8'hC1

`define LSR_GAIN_MAX_BIT   4
`define LSR_GAIN_LOW_BIT   2
`define LSR_RDCLR_BIT      7
`define LSR_SAI_BIT        4
`define LSR_OFF_SIGN_BIT   0
`define LSR_LIGHT_INTERRUPT_FLAG_BIT       4
`define LSR_PROX_INTERRUPT_FLAG_BIT       5

`define LSR_GAIN_CFG_RST   8'h04
`define LSR_INT_CFG_RST    8'h0C
`define LSR_ZERO8          8'h00
`define LSR_ZERO16         16'h0000
`define LSR_ALL_FLAGS      8'hFF
`define LSR_GAIN_UNIT_X2   9'h002
`define LSR_PKG_ID_DEF     4'h5

`endif

// *** inc/lsr_pkg.sv ***
// Types shared by the result/config register bank
package lsr_pkg;
  typedef logic [7:0] lsr_byte_t;
  typedef enum logic [1:0] {OSC_OFF, OSC_RUN, OSC_SLEEP} lsr_osc_state_e;
endpackage

// *** inc/lsr_res_if.sv ***
// Result values and offset settings between register bank and capture
`timescale 1ns/1ns
interface lsr_res_if;
  logic [15:0] red;
  logic [15:0] green;
  logic [15:0] blue;
  logic [7:0]  prox;
  logic        ir_sel;
  logic [7:0]  off_mag;
  logic        off_neg;
  modport capt (input ir_sel, input off_mag, input off_neg,
                output red, output green, output blue, output prox);
  modport regs (output ir_sel, output off_mag, output off_neg,
                input red, input green, input blue, input prox);
endinterface

// *** verilog/lsr_result_capture.sv ***
// Captures channel results at cycle completion, applies proximity offset
`timescale 1ns/1ns
`include "lsr_consts.svh"
module lsr_result_capture
  import lsr_pkg::*;
(
  // Clock and reset
  input  logic        mclk,
  input  logic        reset,
  // Measurement engine
  input  logic        als_done,
  input  logic        prox_done,
  input  logic [15:0] red_raw,
  input  logic [15:0] green_raw,
  input  logic [15:0] ir_raw,
  input  logic [15:0] blue_raw,
  input  logic [7:0]  prox_raw,
  // Results and settings
  lsr_res_if.capt     res
);

  logic signed [9:0] prox_sum;
  lsr_byte_t         prox_next;

  // Positive offset removes crosstalk, so it is subtracted from the raw count
  always_comb begin
    if (res.off_neg) begin
      prox_sum = $signed({2'b00, prox_raw}) + $signed({2'b00, res.off_mag});
    end else begin
      prox_sum = $signed({2'b00, prox_raw}) - $signed({2'b00, res.off_mag});
    end
    if (prox_sum < 0) begin
      prox_next = `LSR_ZERO8;
    end else if (prox_sum > 10'sd255) begin
      prox_next = `LSR_ALL_FLAGS;
    end else begin
      prox_next = prox_sum[7:0];
    end
  end

  // Colour results only move at the end of a light cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      res.red   <= `LSR_ZERO16;
      res.green <= `LSR_ZERO16;
      res.blue  <= `LSR_ZERO16;
    end else if (als_done) begin
      res.red   <= red_raw;
      res.green <= res.ir_sel ? ir_raw : green_raw;
      res.blue  <= blue_raw;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      res.prox <= `LSR_ZERO8;
    end else if (prox_done) begin
      res.prox <= prox_next;
    end
  end

endmodule

// *** verilog/lsr_result_regs.sv ***
// Result, gain extension, sleep-after-interrupt and offset register bank
`timescale 1ns/1ns
`include "lsr_consts.svh"
module lsr_result_regs
  import lsr_pkg::*;
#(
  parameter logic [3:0] PKG_ID = `LSR_PKG_ID_DEF  // Arbitrary value
)
(
  // Clock and reset
  input  logic        mclk,
  input  logic        reset,
  // Register port from the serial interface engine
  input  logic [7:0]  reg_addr,
  input  logic        reg_wr,
  input  logic [7:0]  reg_wdata,
  input  logic        reg_rd,
  output logic [7:0]  reg_rdata,
  // Measurement engine
  input  logic        als_done,
  input  logic        prox_done,
  input  logic [15:0] red_raw,
  input  logic [15:0] green_raw,
  input  logic [15:0] ir_raw,
  input  logic [15:0] blue_raw,
  input  logic [7:0]  prox_raw,
  input  logic [7:0]  flag_set,
  // Rest of the sensor
  input  logic        power_on_bit,
  input  logic        light_interrupt_enable,
  input  logic        prox_interrupt_enable,
  input  logic [1:0]  coarse_light_gain,
  input  logic        infrared_route_select,
  // Control outputs
  output logic        osc_enable,
  output logic        int_pin_n,
  output logic [8:0]  als_gain_x2
);

  lsr_res_if res ();

  lsr_byte_t      gain_extension_config_reg;
  lsr_byte_t      interrupt_sleep_config_reg;
  lsr_byte_t      prox_offset_magnitude_reg;
  lsr_byte_t      prox_offset_sign_reg;
  lsr_byte_t      status_reg;
  lsr_byte_t      status_next;
  lsr_byte_t      status_clr;
  lsr_byte_t      reg_rdata_reg;
  lsr_byte_t      rdata_next;
  logic [8:0]     als_gain_x2_reg;
  logic [8:0]     gain_next;
  lsr_osc_state_e osc_state_reg;
  lsr_osc_state_e osc_state_next;
  logic           gain_max_boost;
  logic           gain_low_select;
  logic           sleep_after_interrupt;
  logic           int_read_clear;
  logic           light_interrupt_flag;
  logic           prox_interrupt_flag;
  logic           int_now;
  logic           int_next;
  logic           meas_done;
  logic           status_wr;
  logic           status_rd_clr;
  logic           clr_any;

  assign gain_max_boost  = gain_extension_config_reg[`LSR_GAIN_MAX_BIT];
  assign gain_low_select = gain_extension_config_reg[`LSR_GAIN_LOW_BIT];
  assign sleep_after_interrupt =
    interrupt_sleep_config_reg[`LSR_SAI_BIT];
  assign int_read_clear  = interrupt_sleep_config_reg[`LSR_RDCLR_BIT];
  assign light_interrupt_flag = status_reg[`LSR_LIGHT_INTERRUPT_FLAG_BIT];
  assign prox_interrupt_flag  = status_reg[`LSR_PROX_INTERRUPT_FLAG_BIT];
  assign meas_done = als_done | prox_done;

  // Settings handed to the capture stage
  assign res.ir_sel  = infrared_route_select;
  assign res.off_mag = prox_offset_magnitude_reg;
  assign res.off_neg = prox_offset_sign_reg[`LSR_OFF_SIGN_BIT];

  lsr_result_capture u_capture (
    .mclk      (mclk),
    .reset     (reset),
    .als_done  (als_done),
    .prox_done (prox_done),
    .red_raw   (red_raw),
    .green_raw (green_raw),
    .ir_raw    (ir_raw),
    .blue_raw  (blue_raw),
    .prox_raw  (prox_raw),
    .res       (res)
  );

  // Configuration registers; reserved bits are kept as plain storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      gain_extension_config_reg  <= `LSR_GAIN_CFG_RST;
      interrupt_sleep_config_reg <= `LSR_INT_CFG_RST;
      prox_offset_magnitude_reg  <= `LSR_ZERO8;
      prox_offset_sign_reg       <= `LSR_ZERO8;
    end else if (reg_wr) begin
      case (reg_addr)
        `LSR_ADDR_GAIN_CFG: gain_extension_config_reg  <= reg_wdata;
        `LSR_ADDR_INT_CFG:  interrupt_sleep_config_reg <= reg_wdata;
        `LSR_ADDR_OFF_MAG:  prox_offset_magnitude_reg  <= reg_wdata;
        `LSR_ADDR_OFF_SIGN: prox_offset_sign_reg       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Status flags: write-one-to-clear or clear-on-read, a new event wins
  assign status_wr     = reg_wr && (reg_addr == `LSR_ADDR_STATUS);
  assign status_rd_clr = reg_rd && (reg_addr == `LSR_ADDR_STATUS)
                         && int_read_clear;
  assign clr_any       = status_wr | status_rd_clr;

  always_comb begin
    status_clr = `LSR_ZERO8;
    if (status_wr) begin
      status_clr = reg_wdata;
    end
    if (status_rd_clr) begin
      status_clr = `LSR_ALL_FLAGS;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      assign status_next[gi] = flag_set[gi]
                               | (status_reg[gi] & ~status_clr[gi]);
    end
  endgenerate

  // One process owns the whole flag byte, so no bit has two writers
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_reg <= `LSR_ZERO8;
    end else begin
      status_reg <= status_next;
    end
  end

  // Interrupt pin is active low
  assign int_now  = (light_interrupt_flag & light_interrupt_enable)
                    | (prox_interrupt_flag & prox_interrupt_enable);
  assign int_next = (status_next[`LSR_LIGHT_INTERRUPT_FLAG_BIT] & light_interrupt_enable)
                    | (status_next[`LSR_PROX_INTERRUPT_FLAG_BIT] & prox_interrupt_enable);
  assign int_pin_n = ~int_now;

  // Oscillator gating
  always_comb begin
    osc_state_next = osc_state_reg;
    case (osc_state_reg)
      OSC_OFF: begin
        if (power_on_bit) begin
          osc_state_next = OSC_RUN;
        end
      end
      OSC_RUN: begin
        if (!power_on_bit) begin
          osc_state_next = OSC_OFF;
        end else if (sleep_after_interrupt && meas_done
                     && int_next) begin
          osc_state_next = OSC_SLEEP;
        end
      end
      OSC_SLEEP: begin
        if (!power_on_bit) begin
          osc_state_next = OSC_OFF;
        end else if (clr_any && !int_next) begin
          osc_state_next = OSC_RUN;
        end
      end
      default: osc_state_next = OSC_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      osc_state_reg <= OSC_OFF;
    end else begin
      osc_state_reg <= osc_state_next;
    end
  end

  // The power bit lives elsewhere and is never touched; the oscillator runs only in OSC_RUN
  assign osc_enable = (osc_state_reg == OSC_RUN);

  // Overall gain in half steps; combinations outside the table still
  // scale by the same rule, which keeps the decode monotonic
  always_comb begin
    gain_next = `LSR_GAIN_UNIT_X2 << {coarse_light_gain, 1'b0};
    if (!gain_low_select) begin
      gain_next = gain_next >> 1;
    end
    if (gain_max_boost) begin
      gain_next = gain_next << 1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      als_gain_x2_reg <= `LSR_GAIN_UNIT_X2;
    end else begin
      als_gain_x2_reg <= gain_next;
    end
  end

  assign als_gain_x2 = als_gain_x2_reg;

  // Read data; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      `LSR_ADDR_STATUS:   rdata_next = status_reg;
      `LSR_ADDR_RED_HI:   rdata_next = res.red[15:8];
      `LSR_ADDR_GRN_LO:   rdata_next = res.green[7:0];
      `LSR_ADDR_GRN_HI:   rdata_next = res.green[15:8];
      `LSR_ADDR_BLU_LO:   rdata_next = res.blue[7:0];
      `LSR_ADDR_BLU_HI:   rdata_next = res.blue[15:8];
      `LSR_ADDR_PROX:     rdata_next = res.prox;
      `LSR_ADDR_PKG_ID:   rdata_next = {4'h0, PKG_ID};
      `LSR_ADDR_GAIN_CFG: rdata_next = gain_extension_config_reg;
      `LSR_ADDR_INT_CFG:  rdata_next = interrupt_sleep_config_reg;
      `LSR_ADDR_OFF_MAG:  rdata_next = prox_offset_magnitude_reg;
      `LSR_ADDR_OFF_SIGN: rdata_next = prox_offset_sign_reg;
      default:            rdata_next = `LSR_ZERO8;
    endcase
  end

  // Holds the last read value so the serial engine can shift at leisure
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_reg <= `LSR_ZERO8;
    end else if (reg_rd) begin
      reg_rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_red_read_back: assert property (
    reg_rd && reg_addr == `LSR_ADDR_RED_HI
    |=> reg_rdata == $past(res.red[15:8]))
    else $error("red high byte read mismatch");

  a_green_low_read: assert property (
    reg_rd && reg_addr == `LSR_ADDR_GRN_LO
    |=> reg_rdata == $past(res.green[7:0]))
    else $error("green low byte read mismatch");

  a_green_ir_mux: assert property (
    als_done && infrared_route_select
    |=> res.green == $past(ir_raw))
    else $error("green did not capture infrared result");

  a_blue_high_read: assert property (
    reg_rd && reg_addr == `LSR_ADDR_BLU_HI
    |=> reg_rdata == $past(res.blue[15:8]))
    else $error("blue high byte read mismatch");

  a_prox_read_back: assert property (
    reg_rd && reg_addr == `LSR_ADDR_PROX
    |=> reg_rdata == $past(res.prox))
    else $error("proximity read mismatch");

  a_gain_top_step: assert property (
    coarse_light_gain == 2'b11 && gain_max_boost && gain_low_select
    |=> als_gain_x2 == 9'h100)
    else $error("gain 128 not decoded");

  a_gain_half_step: assert property (
    coarse_light_gain == 2'b00 && !gain_max_boost && !gain_low_select
    |=> als_gain_x2 == 9'h001)
    else $error("gain one half not decoded");

  a_read_clears_all: assert property (
    status_rd_clr && flag_set == `LSR_ZERO8
    |=> status_reg == `LSR_ZERO8)
    else $error("clear-on-read left a flag set");

  a_write_one_clear: assert property (
    status_wr && flag_set == `LSR_ZERO8 && !status_rd_clr
    |=> (status_reg & $past(reg_wdata)) == `LSR_ZERO8
        && (status_reg & ~$past(reg_wdata))
           == ($past(status_reg) & ~$past(reg_wdata)))
    else $error("write-one-to-clear mismatch");

  a_set_beats_clear: assert property (
    flag_set != `LSR_ZERO8
    |=> (status_reg & $past(flag_set)) == $past(flag_set))
    else $error("flag event lost against a clear");

  a_power_off_gate: assert property (
    !power_on_bit |=> !osc_enable)
    else $error("oscillator running without power bit");

  a_sleep_on_int: assert property (
    osc_state_reg == OSC_RUN && power_on_bit && sleep_after_interrupt
    && meas_done && int_next
    |=> !osc_enable ##1 (!osc_enable || clr_any || $past(clr_any)))
    else $error("sleep after interrupt did not stop oscillator");

  a_sleep_needs_done: assert property (
    osc_state_reg == OSC_RUN && power_on_bit && !meas_done
    |=> osc_enable)
    else $error("oscillator stopped outside cycle completion");

  a_sleep_holds: assert property (
    osc_state_reg == OSC_SLEEP && power_on_bit && !clr_any
    |=> !osc_enable && osc_state_reg == OSC_SLEEP)
    else $error("oscillator restarted without a flag clear");

  a_wake_on_clear: assert property (
    osc_state_reg == OSC_SLEEP && power_on_bit && clr_any && !int_next
    |=> osc_enable)
    else $error("oscillator did not restart after clear");

  a_offset_store: assert property (
    reg_wr && reg_addr == `LSR_ADDR_OFF_MAG
    |=> prox_offset_magnitude_reg == $past(reg_wdata))
    else $error("offset magnitude not stored");

  a_offset_zero: assert property (
    prox_done && res.off_mag == `LSR_ZERO8
    |=> res.prox == $past(prox_raw))
    else $error("zero offset altered proximity result");

  a_result_hold: assert property (
    !als_done && !prox_done
    |=> $stable(res.red) && $stable(res.blue) && $stable(res.prox))
    else $error("result changed without cycle completion");

endmodule

// *** bench/lsr_host_model.sv ***
// Host side of the register port: byte reads, writes and flag clears
`timescale 1ns/1ns
module lsr_host_model (
  // Clock
  input  wire logic       mclk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse, so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Besides dropping the power bit, clearing pending flags is the only way to wake a slept device
  task automatic clr_flags(input logic [7:0] m);
    wr(8'h93, m);
  endtask
endmodule

// *** bench/light_sensor_result_config_regs_tb_top.sv ***
// Self-checking bench for the result and configuration register bank
`timescale 1ns/1ns
`include "lsr_consts.svh"
`define LSR_CHK(got, want) begin num_checks++; if ((got) !== (want)) begin \
  fails++; $display("[ERR] %0t got %h want %h", $time, got, want); end end
module light_sensor_result_config_regs_tb_top
  import lsr_pkg::*;
;
  typedef struct {
    logic [1:0] cg;
    logic       mx;
    logic       lo;
    logic [8:0] x2;
    logic [7:0] mag;
    logic       neg;
    logic [7:0] raw;
    logic [7:0] res;
  } lsr_row_s;

  logic        mclk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        als_done;
  logic        prox_done;
  logic [15:0] red_raw;
  logic [15:0] green_raw;
  logic [15:0] ir_raw;
  logic [15:0] blue_raw;
  logic [7:0]  prox_raw;
  logic [7:0]  flag_set;
  logic        power_on_bit;
  logic        light_interrupt_enable;
  logic        prox_interrupt_enable;
  logic [1:0]  coarse_light_gain;
  logic        infrared_route_select;
  logic        osc_enable;
  logic        int_pin_n;
  logic [8:0]  als_gain_x2;
  int          fails;
  int          num_checks;
  lsr_row_s    rows [7];
  logic [15:0] rst_rows [13];

  lsr_result_regs dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .als_done(als_done), .prox_done(prox_done),
    .red_raw(red_raw), .green_raw(green_raw), .ir_raw(ir_raw),
    .blue_raw(blue_raw), .prox_raw(prox_raw), .flag_set(flag_set),
    .power_on_bit(power_on_bit),
    .light_interrupt_enable(light_interrupt_enable),
    .prox_interrupt_enable(prox_interrupt_enable),
    .coarse_light_gain(coarse_light_gain),
    .infrared_route_select(infrared_route_select),
    .osc_enable(osc_enable), .int_pin_n(int_pin_n),
    .als_gain_x2(als_gain_x2));

  lsr_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic ev(input logic a, input logic p, input logic [7:0] f);
    @(negedge mclk);
    als_done = a;
    prox_done = p;
    flag_set = f;
    @(negedge mclk);
    als_done = 1'b0;
    prox_done = 1'b0;
    flag_set = 8'h00;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    host_u.rd(a, d);
    `LSR_CHK(d, want)
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard: the whole sequence needs far fewer cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    reset = 1'b1;
    als_done = 1'b0;
    prox_done = 1'b0;
    red_raw = 16'h0000;
    green_raw = 16'h0000;
    ir_raw = 16'h0000;
    blue_raw = 16'h0000;
    prox_raw = 8'h00;
    flag_set = 8'h00;
    power_on_bit = 1'b0;
    light_interrupt_enable = 1'b0;
    prox_interrupt_enable = 1'b0;
    coarse_light_gain = 2'h0;
    infrared_route_select = 1'b0;
    fails = 0;
    num_checks = 0;
    rows = '{'{2'h0, 1'b0, 1'b0, 9'h001, 8'h10, 1'b0, 8'h50, 8'h40},
             '{2'h0, 1'b0, 1'b1, 9'h002, 8'h10, 1'b1, 8'h50, 8'h60},
             '{2'h1, 1'b0, 1'b1, 9'h008, 8'hFF, 1'b1, 8'h20, 8'hFF},
             '{2'h2, 1'b0, 1'b1, 9'h020, 8'h30, 1'b0, 8'h20, 8'h00},
             '{2'h3, 1'b0, 1'b1, 9'h080, 8'hFF, 1'b0, 8'hFF, 8'h00},
             '{2'h3, 1'b1, 1'b1, 9'h100, 8'h01, 1'b0, 8'hFF, 8'hFE},
             '{2'h0, 1'b0, 1'b1, 9'h002, 8'h00, 1'b1, 8'h7B, 8'h7B}};
    rst_rows = '{{`LSR_ADDR_RED_HI, 8'h00}, {`LSR_ADDR_GRN_LO, 8'h00},
                 {`LSR_ADDR_GRN_HI, 8'h00}, {`LSR_ADDR_BLU_LO, 8'h00},
                 {`LSR_ADDR_BLU_HI, 8'h00}, {`LSR_ADDR_PROX, 8'h00},
                 {`LSR_ADDR_PKG_ID, {4'h0, `LSR_PKG_ID_DEF}},
                 {`LSR_ADDR_GAIN_CFG, 8'h04}, {`LSR_ADDR_INT_CFG, 8'h0C},
                 {`LSR_ADDR_OFF_MAG, 8'h00}, {`LSR_ADDR_OFF_SIGN, 8'h00},
                 {`LSR_ADDR_STATUS, 8'h00}, {8'hA0, 8'h00}};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    `LSR_CHK(osc_enable, 1'b0)
    `LSR_CHK(int_pin_n, 1'b1)
    // Gain decode and signed offset, one row per setting
    foreach (rows[i]) begin
      coarse_light_gain = rows[i].cg;
      host_u.wr(`LSR_ADDR_GAIN_CFG,
                {3'h0, rows[i].mx, 1'b0, rows[i].lo, 2'h0});
      @(negedge mclk);
      `LSR_CHK(als_gain_x2, rows[i].x2)
      host_u.wr(`LSR_ADDR_OFF_MAG, rows[i].mag);
      host_u.wr(`LSR_ADDR_OFF_SIGN, {7'h00, rows[i].neg});
      prox_raw = rows[i].raw;
      ev(1'b0, 1'b1, 8'h00);
      chk_rd(`LSR_ADDR_OFF_MAG, rows[i].mag);
      chk_rd(`LSR_ADDR_PROX, rows[i].res);
    end
    // Results hold between completions; green follows the routing select
    red_raw = 16'hA1B2;
    green_raw = 16'h1357;
    ir_raw = 16'hFEDC;
    blue_raw = 16'h2468;
    chk_rd(`LSR_ADDR_RED_HI, 8'h00);
    ev(1'b1, 1'b0, 8'h00);
    red_raw = 16'h0000;
    green_raw = 16'h0000;
    blue_raw = 16'h0000;
    chk_rd(`LSR_ADDR_RED_HI, 8'hA1);
    chk_rd(`LSR_ADDR_GRN_LO, 8'h57);
    chk_rd(`LSR_ADDR_GRN_HI, 8'h13);
    chk_rd(`LSR_ADDR_BLU_LO, 8'h68);
    chk_rd(`LSR_ADDR_BLU_HI, 8'h24);
    infrared_route_select = 1'b1;
    chk_rd(`LSR_ADDR_GRN_LO, 8'h57);
    ev(1'b1, 1'b0, 8'h00);
    chk_rd(`LSR_ADDR_GRN_LO, 8'hDC);
    chk_rd(`LSR_ADDR_GRN_HI, 8'hFE);
    // Status flags: write-one clear, then clear on read
    prox_interrupt_enable = 1'b1;
    ev(1'b0, 1'b0, 8'h30);
    `LSR_CHK(int_pin_n, 1'b0)
    chk_rd(`LSR_ADDR_STATUS, 8'h30);
    host_u.clr_flags(8'h20);
    `LSR_CHK(int_pin_n, 1'b1)
    chk_rd(`LSR_ADDR_STATUS, 8'h10);
    host_u.wr(`LSR_ADDR_INT_CFG, 8'h8C);
    chk_rd(`LSR_ADDR_STATUS, 8'h10);
    chk_rd(`LSR_ADDR_STATUS, 8'h00);
    // Sleep after interrupt and wake by flag clear only
    host_u.wr(`LSR_ADDR_INT_CFG, 8'h1C);
    power_on_bit = 1'b1;
    light_interrupt_enable = 1'b1;
    @(negedge mclk);
    `LSR_CHK(osc_enable, 1'b1)
    ev(1'b0, 1'b0, 8'h10);
    `LSR_CHK(osc_enable, 1'b1)
    ev(1'b1, 1'b0, 8'h00);
    `LSR_CHK(osc_enable, 1'b0)
    host_u.wr(`LSR_ADDR_OFF_MAG, 8'h00);
    `LSR_CHK(osc_enable, 1'b0)
    host_u.clr_flags(8'h10);
    @(negedge mclk);
    `LSR_CHK(osc_enable, 1'b1)
    power_on_bit = 1'b0;
    @(negedge mclk);
    `LSR_CHK(osc_enable, 1'b0)
    // A flag event in the same cycle as its clear keeps the flag
    fork
      host_u.clr_flags(8'h10);
      ev(1'b0, 1'b0, 8'h10);
    join
    chk_rd(`LSR_ADDR_STATUS, 8'h10);
    // Mid-run reset restores every value; read-only writes are ignored
    host_u.wr(`LSR_ADDR_OFF_MAG, 8'h5A);
    coarse_light_gain = 2'h0;
    @(negedge mclk);
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    `LSR_CHK(als_gain_x2, 9'h002)
    `LSR_CHK(int_pin_n, 1'b1)
    host_u.wr(`LSR_ADDR_RED_HI, 8'hFF);
    foreach (rst_rows[i]) begin
      chk_rd(rst_rows[i][15:8], rst_rows[i][7:0]);
    end
    wrap_up();
  end
endmodule
